// File: verilog/ir_codec_consts.svh
`ifndef IR_CODEC_CONSTS_SVH
`define IR_CODEC_CONSTS_SVH

// reference clock
`define REF_CLK_MHZ 50
`define REF_CLK_HZ 50000000

// fixed-width optical pulse, time in ns and derived cycles (least time, rounded up)
`define FIXED_PULSE_NS 1627
`define FIXED_PULSE_CYC ((`FIXED_PULSE_NS * `REF_CLK_MHZ + 999) / 1000)
`define OSC_PULSE_EDGES 3

// sixteenth-of-bit timing
`define TICKS_PER_BIT 16
`define PULSE_3_16_TICKS 3
`define MID_START_TICKS 8
`define CTL_DATA_BITS 8

// pin synchroniser slots
`define PIN_COUNT 10
`define PIN_PORT_SEL 0
`define PIN_HOST_TX 1
`define PIN_SERIAL_RX 2
`define PIN_OPTICAL_RX 3
`define PIN_OSC 4
`define PIN_BAUD 5
`define PIN_RATE_SEL 6
`define PIN_STRAP_ONE 7
`define PIN_PULSE_SEL 8
`define PIN_VARIANT 9
`define SETTLE_CYCLES 3'h4

// control byte layout
`define CTL_USER_HI 6
`define CTL_USER_LO 5
`define CTL_PSEL 4
`define CTL_BAUD_HI 3
`define CTL_BAUD_LO 0
`define DEFAULT_BAUD_CODE 4'h6

// 16x divisors from the reference clock
`define BAUD_DIV(rate) (`REF_CLK_HZ / (16 * (rate)))
`define RATE_0 115200
`define RATE_1 57600
`define RATE_2 38400
`define RATE_3 19200
`define RATE_4 14400
`define RATE_5 12800
`define RATE_6 9600
`define RATE_7 7200
`define RATE_8 4800
`define RATE_9 3600
`define RATE_A 2400
`define RATE_B 1800
`define RATE_C 1200

`endif

// File: verilog/ir_codec_pkg.sv
package ir_codec_pkg;
  typedef logic [11:0] div_t;
  typedef logic [3:0] baud_code_t;
  typedef enum logic [1:0] {
    CRX_IDLE = 2'b00,
    CRX_START = 2'b01,
    CRX_DATA = 2'b10
  } ctl_rx_state_e;
  typedef enum logic [1:0] {
    DIR_IDLE = 2'b00,
    DIR_TX = 2'b01,
    DIR_RX = 2'b10
  } link_dir_e;
endpackage

// File: verilog/codec_timing_if.sv
interface codec_timing_if;
  logic tick16;
  logic osc_tick;
  logic fixed_mode;
  logic ref_width;
  logic filter_en;
  logic tx_enable;
  logic rx_enable;
  modport src (output tick16, osc_tick, fixed_mode, ref_width, filter_en, tx_enable, rx_enable);
  modport enc (input tick16, osc_tick, fixed_mode, ref_width, tx_enable);
  modport dec (input tick16, osc_tick, filter_en, rx_enable);
endinterface

// File: verilog/ir_pulse_encoder.sv
`include "ir_codec_consts.svh"

module ir_pulse_encoder (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // timing
  codec_timing_if.enc tim,
  // data
  input wire logic tx_data_i,
  output logic pulse_o
);
  logic [4:0] phase_r;
  logic tx_prev_r;
  logic [7:0] width_r;
  logic pulse_r;
  wire tx_fall = tx_prev_r & ~tx_data_i;
  // repeat one tick into the bit, so a slightly skewed uart edge is already seen
  wire bit_edge = tim.tick16 && (phase_r == 5'(`TICKS_PER_BIT));
  wire bit_start = tx_fall | (bit_edge & ~tx_data_i);
  // RULE_20: pulse per zero bit
  wire fire = tim.tx_enable & bit_start & ~tx_data_i;
  // RULE_15: width source by mode
  wire step = tim.fixed_mode ? (tim.ref_width ? 1'b1 : tim.osc_tick) : tim.tick16;
  // RULE_06: three oscillator edges
  wire [7:0] limit = !tim.fixed_mode ? 8'(`PULSE_3_16_TICKS) :
                     (tim.ref_width ? 8'(`FIXED_PULSE_CYC) : 8'(`OSC_PULSE_EDGES));

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_r <= '0;
      tx_prev_r <= 1'b1;
      width_r <= '0;
      pulse_r <= 1'b0;
    end else begin
      tx_prev_r <= tx_data_i;
      if (tx_fall) begin
        phase_r <= '0;
      end else if (bit_edge) begin
        phase_r <= 5'h01;
      end else if (tim.tick16) begin
        phase_r <= phase_r + 5'h01;
      end
      if (fire) begin
        pulse_r <= 1'b1;
        width_r <= '0;
      end else if (pulse_r && step) begin
        width_r <= width_r + 8'h01;
        if (width_r + 8'h01 >= limit) begin
          pulse_r <= 1'b0;
        end
      end
    end
  end

  assign pulse_o = pulse_r;
endmodule

// File: verilog/ir_pulse_decoder.sv
`include "ir_codec_consts.svh"

module ir_pulse_decoder (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // timing
  codec_timing_if.dec tim,
  // data, optical input is active low
  input wire logic optical_rx_i,
  output logic bit_low_o
);
  logic armed_r;
  logic [1:0] osc_seen_r;
  logic low_r;
  logic [3:0] stretch_r;
  // RULE_08: low held across a full oscillator period
  wire long_enough = tim.osc_tick && (osc_seen_r == 2'h1);
  // RULE_09: no filter in 3/16 mode
  wire accept = tim.rx_enable & armed_r & ~optical_rx_i & (~tim.filter_en | long_enough);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      armed_r <= 1'b1;
      osc_seen_r <= '0;
      low_r <= 1'b0;
      stretch_r <= '0;
    end else begin
      if (optical_rx_i) begin
        armed_r <= 1'b1;
        osc_seen_r <= '0;
      end else if (accept) begin
        armed_r <= 1'b0;
      end else if (tim.osc_tick && osc_seen_r != 2'h2) begin
        osc_seen_r <= osc_seen_r + 2'h1;
      end
      // RULE_04: stretch on baud ticks
      if (accept) begin
        low_r <= 1'b1;
        stretch_r <= '0;
      end else if (low_r && tim.tick16) begin
        stretch_r <= stretch_r + 4'h1;
        if (stretch_r == 4'(`TICKS_PER_BIT - 1)) begin
          low_r <= 1'b0;
        end
      end
    end
  end

  assign bit_low_o = low_r;
endmodule

// File: verilog/ir_pulse_codec_port_mux.sv
`include "ir_codec_consts.svh"

// What this block does
// RULE_01: port select low routes uart to optical pins, serial side blocked.
// RULE_02: port select high routes uart to serial side pins, optical blocked.
// RULE_03: half duplex; transmit blocks receive and receive blocks transmit.
// RULE_04: dual clock uses baud clock to stretch, oscillator to shorten and filter.
// RULE_05: single clock straps give 3/16 pulses with filtering off.
// RULE_06: fixed pulses are three oscillator edges regardless of baud rate; the crystal variant times them as FIXED_PULSE_CYC reference cycles instead.
// RULE_07: oscillator and baud clock are unrelated and sampled separately.
// RULE_08: fixed mode drops optical pulses shorter than one oscillator period; on the crystal variant the code applies no filter in fixed mode.
// RULE_09: 3/16 mode applies no filtering to the optical input.
// RULE_10: both straps low select filtered fixed mode on dual clock variant.
// RULE_11: rate select low means serial and optical inputs carry data.
// RULE_12: rate select high captures seven low bits of serial word as control.
// RULE_13: new rate takes effect only when rate select returns low.
// RULE_14: control byte: ignored top, two user bits, pulse select, baud code.
// RULE_15: pulse select one gives fixed width, zero gives 3/16 bit.
// RULE_16: baud codes 0 to C map 115.2 down to 1.2 kbit/s.
// RULE_17: fixed width is the better choice where power matters.
// RULE_18: reset clears registers and starts at 9600 bit/s.
// RULE_19: control word is start bit plus eight bits, no stop, current rate.
// RULE_20: one pulse per zero bit; each accepted pulse becomes a low bit.
module ir_pulse_codec_port_mux (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // uart side
  input wire logic host_tx_in_i,
  output logic host_rx_o,
  input wire logic uart_aux_output_one_i,
  // clocks from the uart
  input wire logic oscillator_in_i,
  input wire logic baud_clk_i,
  // straps and control
  input wire logic strap_one_i,
  input wire logic pulse_width_select_i,
  input wire logic crystal_variant_i,
  input wire logic rate_or_data_select_i,
  // serial side
  input wire logic serial_side_rx_i,
  output logic serial_side_tx_o,
  // optical transceiver
  input wire logic optical_rx_i,
  output logic optical_tx_o,
  output logic transceiver_supply_out_o,
  // user bits of the control byte
  output logic [1:0] user_bits_o
);
  codec_timing_if tim ();

  // pin synchronisers
  wire [`PIN_COUNT-1:0] pins_raw = {crystal_variant_i, pulse_width_select_i, strap_one_i,
                                    rate_or_data_select_i, baud_clk_i, oscillator_in_i,
                                    optical_rx_i, serial_side_rx_i, host_tx_in_i,
                                    uart_aux_output_one_i};
  logic [`PIN_COUNT-1:0] pins_r;
  logic [`PIN_COUNT-1:0] pins_prev_r;

  // RULE_07: each clock pin sampled on its own
  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_sync
      logic [2:0] sh_r;
      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          sh_r <= '0;
          pins_r[gi] <= 1'b0;
          pins_prev_r[gi] <= 1'b0;
        end else begin
          sh_r <= {sh_r[1:0], pins_raw[gi]};
          if (sh_r[1] == sh_r[2]) begin
            pins_r[gi] <= sh_r[2];
          end
          pins_prev_r[gi] <= pins_r[gi];
        end
      end
    end
  endgenerate

  logic ready_r;
  wire port_sel = pins_r[`PIN_PORT_SEL];
  wire host_tx = pins_r[`PIN_HOST_TX] | ~ready_r;
  wire serial_rx = pins_r[`PIN_SERIAL_RX] | ~ready_r;
  wire opt_rx = pins_r[`PIN_OPTICAL_RX] | ~ready_r;
  wire rate_sel = pins_r[`PIN_RATE_SEL];
  wire osc_rise = ready_r & pins_r[`PIN_OSC] & ~pins_prev_r[`PIN_OSC];
  wire baud_rise = ready_r & pins_r[`PIN_BAUD] & ~pins_prev_r[`PIN_BAUD];
  wire rate_sel_fall = ready_r & ~rate_sel & pins_prev_r[`PIN_RATE_SEL];
  wire host_tx_fall = ready_r & ~pins_r[`PIN_HOST_TX] & pins_prev_r[`PIN_HOST_TX];

  // settle counter, then straps are caught
  logic [2:0] settle_r;
  logic strap_one_r;
  logic strap_psel_r;
  logic variant_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      settle_r <= '0;
      ready_r <= 1'b0;
      strap_one_r <= 1'b0;
      strap_psel_r <= 1'b0;
      variant_r <= 1'b0;
    end else if (!ready_r) begin
      settle_r <= settle_r + 3'h1;
      if (settle_r == `SETTLE_CYCLES) begin
        ready_r <= 1'b1;
        strap_one_r <= pins_r[`PIN_STRAP_ONE];
        strap_psel_r <= pins_r[`PIN_PULSE_SEL];
        variant_r <= pins_r[`PIN_VARIANT];
      end
    end
  end

  // control byte state
  ir_codec_pkg::baud_code_t baud_code_r;
  logic psel_r;
  logic [1:0] user_r;
  logic [6:0] pend_r;
  logic pend_valid_r;

  // RULE_16: baud code to 16x divisor
  ir_codec_pkg::div_t div_max;
  always_comb begin
    case (baud_code_r)
      4'h0: div_max = ir_codec_pkg::div_t'(`BAUD_DIV(`RATE_0));
      4'h1: div_max = ir_codec_pkg::div_t'(`BAUD_DIV(`RATE_1));
      4'h2: div_max = ir_codec_pkg::div_t'(`BAUD_DIV(`RATE_2));
      4'h3: div_max = ir_codec_pkg::div_t'(`BAUD_DIV(`RATE_3));
      4'h4: div_max = ir_codec_pkg::div_t'(`BAUD_DIV(`RATE_4));
      4'h5: div_max = ir_codec_pkg::div_t'(`BAUD_DIV(`RATE_5));
      4'h6: div_max = ir_codec_pkg::div_t'(`BAUD_DIV(`RATE_6));
      4'h7: div_max = ir_codec_pkg::div_t'(`BAUD_DIV(`RATE_7));
      4'h8: div_max = ir_codec_pkg::div_t'(`BAUD_DIV(`RATE_8));
      4'h9: div_max = ir_codec_pkg::div_t'(`BAUD_DIV(`RATE_9));
      4'hA: div_max = ir_codec_pkg::div_t'(`BAUD_DIV(`RATE_A));
      4'hB: div_max = ir_codec_pkg::div_t'(`BAUD_DIV(`RATE_B));
      4'hC: div_max = ir_codec_pkg::div_t'(`BAUD_DIV(`RATE_C));
      default: div_max = ir_codec_pkg::div_t'(`BAUD_DIV(`RATE_6));
    endcase
  end

  ir_codec_pkg::div_t div_cnt_r;
  logic div_tick_r;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt_r <= '0;
      div_tick_r <= 1'b0;
    end else if (host_tx_fall) begin
      // restart on a start edge, so a 3/16 pulse spans whole ticks
      div_cnt_r <= '0;
      div_tick_r <= 1'b0;
    end else begin
      div_tick_r <= 1'b0;
      if (div_cnt_r >= div_max - ir_codec_pkg::div_t'(1)) begin
        div_cnt_r <= '0;
        div_tick_r <= 1'b1;
      end else begin
        div_cnt_r <= div_cnt_r + ir_codec_pkg::div_t'(1);
      end
    end
  end

  // RULE_04: baud clock as 16x reference on the dual clock variant
  wire tick16 = variant_r ? div_tick_r : baud_rise;

  // RULE_05: strap one high selects 3/16, no filter
  // RULE_10: both straps low select filtered fixed width
  // RULE_15: control bit selects the width on the crystal variant
  wire fixed_mode = variant_r ? psel_r : (~strap_one_r & ~strap_psel_r);

  // control word receiver: start bit plus eight bits, no stop
  ir_codec_pkg::ctl_rx_state_e crx_state_r;
  logic [3:0] crx_tick_r;
  logic [2:0] crx_bit_r;
  logic [7:0] crx_shift_r;
  logic serial_rx_prev_r;
  wire crx_start = rate_sel & serial_rx_prev_r & ~serial_rx;
  wire [7:0] crx_word = {serial_rx, crx_shift_r[7:1]};

  // RULE_12: capture while rate select is high
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      crx_state_r <= ir_codec_pkg::CRX_IDLE;
      crx_tick_r <= '0;
      crx_bit_r <= '0;
      crx_shift_r <= '0;
      serial_rx_prev_r <= 1'b1;
    end else begin
      serial_rx_prev_r <= serial_rx;
      case (crx_state_r)
        ir_codec_pkg::CRX_IDLE: begin
          crx_tick_r <= '0;
          if (crx_start) begin
            crx_state_r <= ir_codec_pkg::CRX_START;
          end
        end
        ir_codec_pkg::CRX_START: begin
          if (!rate_sel) begin
            crx_state_r <= ir_codec_pkg::CRX_IDLE;
          end else if (tick16) begin
            crx_tick_r <= crx_tick_r + 4'h1;
            if (crx_tick_r == 4'(`MID_START_TICKS - 1)) begin
              crx_tick_r <= '0;
              crx_bit_r <= '0;
              crx_state_r <= serial_rx ? ir_codec_pkg::CRX_IDLE : ir_codec_pkg::CRX_DATA;
            end
          end
        end
        ir_codec_pkg::CRX_DATA: begin
          if (!rate_sel) begin
            crx_state_r <= ir_codec_pkg::CRX_IDLE;
          end else if (tick16) begin
            crx_tick_r <= crx_tick_r + 4'h1;
            if (crx_tick_r == 4'(`TICKS_PER_BIT - 1)) begin
              crx_shift_r <= crx_word;
              crx_bit_r <= crx_bit_r + 3'h1;
              if (crx_bit_r == 3'(`CTL_DATA_BITS - 1)) begin
                crx_state_r <= ir_codec_pkg::CRX_IDLE;
              end
            end
          end
        end
        default: crx_state_r <= ir_codec_pkg::CRX_IDLE;
      endcase
    end
  end

  wire crx_done = (crx_state_r == ir_codec_pkg::CRX_DATA) && rate_sel && tick16 &&
                  (crx_tick_r == 4'(`TICKS_PER_BIT - 1)) &&
                  (crx_bit_r == 3'(`CTL_DATA_BITS - 1));

  // control registers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // RULE_18: cleared, default rate
      baud_code_r <= `DEFAULT_BAUD_CODE;
      psel_r <= 1'b0;
      user_r <= '0;
      pend_r <= '0;
      pend_valid_r <= 1'b0;
    end else begin
      if (crx_done) begin
        pend_r <= crx_word[6:0];
        pend_valid_r <= 1'b1;
      // RULE_13: applied on rate select fall
      end else if (rate_sel_fall && pend_valid_r) begin
        pend_valid_r <= 1'b0;
        // RULE_14: field split
        user_r <= pend_r[`CTL_USER_HI:`CTL_USER_LO];
        psel_r <= pend_r[`CTL_PSEL];
        baud_code_r <= pend_r[`CTL_BAUD_HI:`CTL_BAUD_LO];
      end
    end
  end

  // half duplex direction
  ir_codec_pkg::link_dir_e dir_r;
  logic [3:0] tx_hold_r;
  logic dec_low;
  logic enc_pulse;
  // RULE_11: data only while rate select is low
  wire data_mode = ~rate_sel;
  wire rx_active = port_sel ? ~serial_rx : dec_low;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dir_r <= ir_codec_pkg::DIR_IDLE;
      tx_hold_r <= '0;
    end else begin
      if (!host_tx) begin
        tx_hold_r <= 4'(`TICKS_PER_BIT - 1);
      end else if (tick16 && tx_hold_r != 4'h0) begin
        tx_hold_r <= tx_hold_r - 4'h1;
      end
      // RULE_03: one direction at a time
      case (dir_r)
        ir_codec_pkg::DIR_IDLE: begin
          if (data_mode && !host_tx) begin
            dir_r <= ir_codec_pkg::DIR_TX;
          end else if (data_mode && rx_active) begin
            dir_r <= ir_codec_pkg::DIR_RX;
          end
        end
        ir_codec_pkg::DIR_TX: begin
          if (host_tx && tx_hold_r == 4'h0 && !enc_pulse) begin
            dir_r <= ir_codec_pkg::DIR_IDLE;
          end
        end
        ir_codec_pkg::DIR_RX: begin
          if (!rx_active) begin
            dir_r <= ir_codec_pkg::DIR_IDLE;
          end
        end
        default: dir_r <= ir_codec_pkg::DIR_IDLE;
      endcase
    end
  end

  wire tx_ok = data_mode & (dir_r != ir_codec_pkg::DIR_RX);
  wire rx_ok = data_mode & (dir_r != ir_codec_pkg::DIR_TX) & ~(dir_r == ir_codec_pkg::DIR_IDLE & ~host_tx);

  assign tim.tick16 = tick16;
  assign tim.osc_tick = osc_rise;
  assign tim.fixed_mode = fixed_mode;
  assign tim.ref_width = variant_r;
  // RULE_08: filter only with an oscillator present
  assign tim.filter_en = fixed_mode & ~variant_r;
  assign tim.tx_enable = tx_ok & ~port_sel;
  assign tim.rx_enable = rx_ok & ~port_sel;

  ir_pulse_encoder u_enc (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .tim(tim.enc),
    .tx_data_i(host_tx),
    .pulse_o(enc_pulse)
  );

  ir_pulse_decoder u_dec (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .tim(tim.dec),
    .optical_rx_i(opt_rx),
    .bit_low_o(dec_low)
  );

  // port multiplexer
  // RULE_01: optical route, serial side idle
  // RULE_02: serial route, optical idle
  wire opt_tx_nxt = ~port_sel & enc_pulse;
  wire ser_tx_nxt = port_sel ? (host_tx | ~tx_ok) : 1'b1;
  wire host_rx_nxt = port_sel ? (serial_rx | ~rx_ok) : ~dec_low;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      optical_tx_o <= 1'b0;
      serial_side_tx_o <= 1'b1;
      host_rx_o <= 1'b1;
      transceiver_supply_out_o <= 1'b0;
      user_bits_o <= '0;
    end else begin
      optical_tx_o <= opt_tx_nxt;
      serial_side_tx_o <= ser_tx_nxt;
      host_rx_o <= host_rx_nxt;
      transceiver_supply_out_o <= ready_r;
      user_bits_o <= user_r;
    end
  end
endmodule

// File: tb/ir_codec_monitor.sv
module ir_codec_monitor (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // watched pins
  input wire logic host_tx_in_i,
  input wire logic host_rx_o,
  input wire logic uart_aux_output_one_i,
  input wire logic oscillator_in_i,
  input wire logic crystal_variant_i,
  input wire logic rate_or_data_select_i,
  input wire logic serial_side_rx_i,
  input wire logic serial_side_tx_o,
  input wire logic optical_rx_i,
  input wire logic optical_tx_o,
  input wire logic [1:0] user_bits_o
);
  logic [7:0] tx_hist_r;
  logic [7:0] rx_hist_r;
  logic [7:0] rs_hist_r;
  logic osc_d_r;
  logic [3:0] osc_cnt_r;
  wire osc_rise = oscillator_in_i & ~osc_d_r;
  wire [3:0] osc_cnt_nxt = optical_tx_o ? osc_cnt_r + {3'h0, osc_rise} : 4'h0;
  // raw pin history, so the sync delay becomes a window
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_hist_r <= 8'hFF;
      rx_hist_r <= 8'hFF;
      rs_hist_r <= 8'h00;
      osc_d_r <= 1'b0;
      osc_cnt_r <= 4'h0;
    end else begin
      tx_hist_r <= {tx_hist_r[6:0], host_tx_in_i};
      rx_hist_r <= {rx_hist_r[6:0], optical_rx_i & serial_side_rx_i};
      rs_hist_r <= {rs_hist_r[6:0], rate_or_data_select_i};
      osc_d_r <= oscillator_in_i;
      osc_cnt_r <= osc_cnt_nxt;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_opt_blocks_ser;
    (!uart_aux_output_one_i) [*8] |-> serial_side_tx_o;
  endproperty
  a_opt_blocks_ser: assert property (p_opt_blocks_ser)
    else $error("serial side driven on optical port");
  property p_ser_blocks_opt;
    uart_aux_output_one_i [*8] |-> !optical_tx_o;
  endproperty
  a_ser_blocks_opt: assert property (p_ser_blocks_opt)
    else $error("flash on serial port");
  property p_ser_route;
    (uart_aux_output_one_i && !rate_or_data_select_i && !host_tx_in_i && host_rx_o) [*8]
      |-> !serial_side_tx_o;
  endproperty
  a_ser_route: assert property (p_ser_route)
    else $error("serial transmit not routed");
  property p_half_duplex;
    (optical_tx_o || !serial_side_tx_o) |-> host_rx_o;
  endproperty
  a_half_duplex: assert property (p_half_duplex)
    else $error("receive active while sending");
  property p_rate_blocks;
    rate_or_data_select_i [*8] |-> !optical_tx_o && serial_side_tx_o;
  endproperty
  a_rate_blocks: assert property (p_rate_blocks)
    else $error("data sent during control word");
  property p_tx_cause;
    $rose(optical_tx_o) |-> !(&tx_hist_r[7:3]);
  endproperty
  a_tx_cause: assert property (p_tx_cause)
    else $error("flash without zero bit");
  property p_rx_cause;
    $fell(host_rx_o) |-> !(&rx_hist_r[7:2]);
  endproperty
  a_rx_cause: assert property (p_rx_cause)
    else $error("low bit without received pulse");
  property p_osc_width;
    $fell(optical_tx_o) && !crystal_variant_i |-> osc_cnt_r inside {[2:3]};
  endproperty
  a_osc_width: assert property (p_osc_width)
    else $error("flash not three clock edges");
  property p_user_apply;
    $changed(user_bits_o) |-> (|rs_hist_r[7:4]) && !(|rs_hist_r[1:0]);
  endproperty
  a_user_apply: assert property (p_user_apply)
    else $error("control applied off select drop");
  c_flash: cover property ($rose(optical_tx_o));
  c_rx_bit: cover property ($fell(host_rx_o));
  c_user: cover property ($changed(user_bits_o));
endmodule

bind ir_pulse_codec_port_mux ir_codec_monitor u_ir_codec_monitor (
  .ref_clk_i, .arst_n_i, .host_tx_in_i, .host_rx_o, .uart_aux_output_one_i,
  .oscillator_in_i, .crystal_variant_i, .rate_or_data_select_i, .serial_side_rx_i,
  .serial_side_tx_o, .optical_rx_i, .optical_tx_o, .user_bits_o
);

// File: tb/ir_transceiver_model.sv
module ir_transceiver_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // emitter side
  input wire logic led_drive_i,
  output int flash_cnt_o,
  output int flash_width_o,
  // detector, low while light is seen
  output logic photo_rx_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int run;
  initial begin
    photo_rx_n_o = 1'b1;
    flash_cnt_o = 0;
    flash_width_o = 0;
    run = 0;
  end
  always @(posedge ref_clk_i) begin
    if (led_drive_i === 1'b1 && arst_n_i) begin
      run <= run + 1;
    end else if (run != 0) begin
      flash_width_o <= run;
      flash_cnt_o <= flash_cnt_o + 1;
      run <= 0;
    end
  end
  // detector output idles high on its pull-up
  task automatic flash(input int w);
    @(posedge ref_clk_i);
    photo_rx_n_o <= 1'b0;
    repeat (w) @(posedge ref_clk_i);
    photo_rx_n_o <= 1'b1;
  endtask
endmodule

// File: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic host_tx = 1'b1, ser_rx = 1'b1, port_sel = 1'b0, rate_sel = 1'b0;
  logic osc_raw = 1'b0, baud_clk = 1'b0, single = 1'b0;
  logic strap_one = 1'b0, pulse_sel = 1'b0, xtal = 1'b0;
  logic host_rx, ser_tx, opt_rx_n, opt_tx, supply;
  logic [1:0] user_bits, exp_user;
  logic [15:0] lfsr = 16'h0006;
  int error_cnt = 0;
  int cmp_count = 0;
  int cur_div, flashes, last_w;
  int rates[13] = '{115200, 57600, 38400, 19200, 14400, 12800, 9600, 7200, 4800, 3600,
                    2400, 1800, 1200};
  always #10 ref_clk_i = ~ref_clk_i;
  // unrelated oscillator and 16x baud clock
  always #268.4 osc_raw = ~osc_raw;
  always #271.3 baud_clk = ~baud_clk;
  ir_pulse_codec_port_mux u_ir_pulse_codec_port_mux (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .host_tx_in_i(host_tx),
    .host_rx_o(host_rx),
    .uart_aux_output_one_i(port_sel),
    .oscillator_in_i(single ? baud_clk : osc_raw),
    .baud_clk_i(baud_clk),
    .strap_one_i(strap_one),
    .pulse_width_select_i(pulse_sel),
    .crystal_variant_i(xtal),
    .rate_or_data_select_i(rate_sel),
    .serial_side_rx_i(ser_rx),
    .serial_side_tx_o(ser_tx),
    .optical_rx_i(opt_rx_n),
    .optical_tx_o(opt_tx),
    .transceiver_supply_out_o(supply),
    .user_bits_o(user_bits)
  );
  ir_transceiver_model u_ir_transceiver_model (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .led_drive_i(opt_tx),
    .flash_cnt_o(flashes),
    .flash_width_o(last_w),
    .photo_rx_n_o(opt_rx_n)
  );
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int div_of(input int code);
    return 50000000 / (16 * rates[code]);
  endfunction
  // fixed flash is 1627 ns rounded up to whole cycles
  function automatic int exp_width(input int code, input logic fixed);
    return fixed ? (1627 + 19) / 20 : 3 * div_of(code);
  endfunction
  function automatic logic in_rng(input int v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // straps only move under reset, they are caught once after release
  task automatic do_reset(input logic x, input logic s1, input logic s0, input logic sg);
    arst_n_i <= 1'b0;
    xtal <= x;
    strap_one <= s1;
    pulse_sel <= s0;
    single <= sg;
    exp_user = 2'h0;
    cyc(3);
    check("reset levels", {opt_tx, ser_tx, host_rx, supply, user_bits}, 6'h18);
    arst_n_i <= 1'b1;
    cyc(12);
    check("supply", supply, 1'b1);
  endtask
  // bits go out lsb first; bit cycles kept a hair short of sixteen ticks
  task automatic send_word(input logic [9:0] bits, input int n, input int bc, input logic ser);
    for (int i = 0; i < n; i++) begin
      if (ser) ser_rx <= bits[i];
      else host_tx <= bits[i];
      cyc(bc);
    end
    if (ser) ser_rx <= 1'b1;
    else host_tx <= 1'b1;
  endtask
  task automatic byte_tx(input logic [7:0] d, input int lo, input int hi);
    int c0;
    c0 = flashes;
    send_word({1'b1, d, 1'b0}, 10, 433, 1'b0);
    cyc(20);
    check("flashes", flashes - c0, 9 - $countones(d));
    check("flash width", in_rng(last_w, lo, hi), 1'b1);
  endtask
  task automatic rx_probe(input int w, input logic exp_low);
    logic seen_low;
    seen_low = 1'b0;
    u_ir_transceiver_model.flash(w);
    repeat (30) begin
      @(posedge ref_clk_i);
      if (host_rx === 1'b0) seen_low = 1'b1;
    end
    check("rx low", seen_low, exp_low);
    cyc(600);
    check("rx idle", host_rx, 1'b1);
  endtask
  task automatic tx_bit(input int exp_w);
    send_word(10'h000, 1, 16 * cur_div - 1, 1'b0);
    cyc(100);
    check("xtal width", in_rng(last_w, exp_w - 2, exp_w + 2), 1'b1);
  endtask
  task automatic prog(input logic [7:0] b);
    rate_sel <= 1'b1;
    cyc(10);
    // start and eight bits, no stop
    send_word({1'b1, b, 1'b0}, 9, 16 * cur_div - 1, 1'b1);
    cyc(20);
    check("user pending", user_bits, exp_user);
    rate_sel <= 1'b0;
    cyc(10);
    exp_user = b[6:5];
    check("user bits", user_bits, exp_user);
    cur_div = div_of(int'(b[3:0]));
    tx_bit(exp_width(int'(b[3:0]), b[4]));
  endtask
  initial begin
    cyc(95000);
    error_cnt++;
    final_report();
  end
  initial begin
    do_reset(1'b0, 1'b0, 1'b0, 1'b0);
    byte_tx(8'h00, 50, 90);
    byte_tx(lfsr[7:0], 50, 90);
    lfsr = lfsr_next(lfsr);
    rx_probe(6, 1'b0);
    rx_probe(70, 1'b1);
    host_tx <= 1'b0;
    cyc(10);
    rx_probe(70, 1'b0);
    host_tx <= 1'b1;
    port_sel <= 1'b1;
    cyc(600);
    flashes_base: begin
      int c0;
      c0 = flashes;
      host_tx <= 1'b0;
      cyc(10);
      check("ser tx", ser_tx, 1'b0);
      host_tx <= 1'b1;
      cyc(600);
      ser_rx <= 1'b0;
      cyc(10);
      check("ser rx", host_rx, 1'b0);
      ser_rx <= 1'b1;
      cyc(10);
      rx_probe(70, 1'b0);
      check("no flash", flashes - c0, 0);
    end
    port_sel <= 1'b0;
    cyc(10);
    ser_rx <= 1'b0;
    cyc(10);
    check("ser rx blocked", host_rx, 1'b1);
    ser_rx <= 1'b1;
    host_tx <= 1'b0;
    cyc(10);
    check("ser tx blocked", ser_tx, 1'b1);
    host_tx <= 1'b1;
    cyc(600);
    do_reset(1'b0, 1'b1, 1'b0, 1'b1);
    byte_tx(8'h00, 75, 90);
    rx_probe(6, 1'b1);
    do_reset(1'b1, 1'b0, 1'b0, 1'b0);
    cur_div = div_of(6);
    tx_bit(exp_width(6, 1'b0));
    prog(8'hD0);
    for (int i = 0; i < 2; i++) begin
      prog({lfsr[7:5], 1'b0, 4'(lfsr[3:0] % 3)});
      lfsr = lfsr_next(lfsr);
    end
    final_report();
  end
endmodule
